//--- hw/ldpwm_top.sv
`timescale 1ns/1ps
module ldpwm_top
  import ldpwm_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR    = 7'h2C,   // Arbitrary value
  parameter int         NCH         = 6,
  parameter int         STEP_DIV    = 490,
  parameter int         EN_LOW_CNT  = EN_LOW_CYC,
  parameter int         PWM_LOW_CNT = PWM_LOW_CYC
) (
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           arst_n,
  // Serial register port
  input  wire logic           scl_i,
  input  wire logic           sda_i,
  output logic                sda_o,
  output logic                sda_oe_n,
  // Control pins
  input  wire logic           en_i,
  input  wire logic           pwm_i,
  input  wire logic           dimming_freq_resistor_pin_high,
  // Channel drive
  output logic [NCH-1:0]      ch_on,
  output logic [7:0]          ch_current_level,
  output logic                shutdown
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [NPINS-1:0] raw;
  logic [NPINS-1:0] s1_q;
  logic [NPINS-1:0] s2_q;
  logic [NPINS-1:0] s3_q;
  logic [NPINS-1:0] filt_q;
  logic [NPINS-1:0] prev_q;

  assign raw = {dimming_freq_resistor_pin_high, pwm_i, en_i, sda_i, scl_i};

  genvar gp;
  generate
    for (gp = 0; gp < NPINS; gp++) begin : g_sync
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          s1_q[gp]   <= PIN_RST[gp];
          s2_q[gp]   <= PIN_RST[gp];
          s3_q[gp]   <= PIN_RST[gp];
          filt_q[gp] <= PIN_RST[gp];
          prev_q[gp] <= PIN_RST[gp];
        end else begin
          s1_q[gp]   <= raw[gp];
          s2_q[gp]   <= s1_q[gp];
          s3_q[gp]   <= s2_q[gp];
          // Change only counts once two stages agree
          if (s2_q[gp] == s3_q[gp]) begin
            filt_q[gp] <= s3_q[gp];
          end
          prev_q[gp] <= filt_q[gp];
        end
      end
    end
  endgenerate

  logic scl_f;
  logic sda_f;
  logic en_f;
  logic pwm_f;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  assign scl_f     = filt_q[PIN_SCL];
  assign sda_f     = filt_q[PIN_SDA];
  assign en_f      = filt_q[PIN_EN];
  assign pwm_f     = filt_q[PIN_PWM];
  assign scl_rise  = scl_f & ~prev_q[PIN_SCL];
  assign scl_fall  = ~scl_f & prev_q[PIN_SCL];
  assign bus_start = scl_f & prev_q[PIN_SCL] & ~sda_f & prev_q[PIN_SDA];
  assign bus_stop  = scl_f & prev_q[PIN_SCL] & sda_f & ~prev_q[PIN_SDA];

  // ----------------------------------------
  // Straps caught after reset release
  // ----------------------------------------
  logic [2:0] strap_cnt_q;
  logic       pins_gnd_q;
  logic       direct_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_cnt_q <= '0;
      pins_gnd_q  <= 1'b0;
      direct_q    <= 1'b0;
    end else if (strap_cnt_q < STRAP_AT) begin
      strap_cnt_q <= strap_cnt_q + 3'h1;
    end else if (strap_cnt_q == STRAP_AT) begin
      // Grounded bus pins force input-only or direct dimming
      // Sampled once only: every START also holds both bus pins low
      strap_cnt_q <= strap_cnt_q + 3'h1;
      pins_gnd_q  <= ~scl_f & ~sda_f;
      direct_q    <= ~scl_f & ~sda_f & filt_q[PIN_FREQ];
    end
  end

  // ----------------------------------------
  // Shutdown timers
  // ----------------------------------------
  logic [19:0] en_cnt_q;
  logic [19:0] pwm_cnt_q;
  logic        en_off_q;
  logic        pwm_off_q;
  logic [7:0]  mode_q;
  logic        uses_input;

  assign uses_input = pins_gnd_q | (mode_q != MODE_REG);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      en_cnt_q <= '0;
      en_off_q <= 1'b0;
    end else if (en_f) begin
      en_cnt_q <= '0;
      en_off_q <= 1'b0;
    end else if (en_cnt_q >= 20'(EN_LOW_CNT)) begin
      en_off_q <= 1'b1;
    end else begin
      en_cnt_q <= en_cnt_q + 20'h1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pwm_cnt_q <= '0;
      pwm_off_q <= 1'b0;
    end else if (pwm_f || !uses_input) begin
      pwm_cnt_q <= '0;
      pwm_off_q <= 1'b0;
    end else if (pwm_cnt_q >= 20'(PWM_LOW_CNT)) begin
      pwm_off_q <= 1'b1;
    end else begin
      pwm_cnt_q <= pwm_cnt_q + 20'h1;
    end
  end

  assign shutdown = en_off_q | pwm_off_q;

  // ----------------------------------------
  // Serial register port
  // ----------------------------------------
  ldpwm_ser_t st_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic [7:0] ptr_q;
  logic       ack_q;
  logic       rw_q;
  logic       nack_q;
  logic       wr_en;
  logic [7:0] bright_q;
  logic [7:0] dc_q;
  logic [7:0] rd_val;
  logic [7:0] rd_next;

  function automatic logic [7:0] reg_read(input logic [7:0] a,
                                          input logic [7:0] b,
                                          input logic [7:0] m,
                                          input logic [7:0] d);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      ADDR_BRIGHT: v = b;
      ADDR_MODE:   v = m;
      ADDR_DC:     v = d;
      default:     v = 8'h00;
    endcase
    return v;
  endfunction

  assign rd_val  = reg_read(ptr_q, bright_q, mode_q, dc_q);
  assign rd_next = reg_read(ptr_q + 8'h01, bright_q, mode_q, dc_q);
  assign wr_en   = scl_fall & ~ack_q & (bit_q == BYTE_BITS) & (st_q == SER_WDATA);
  assign sda_o   = 1'b0;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q     <= SER_IDLE;
      bit_q    <= '0;
      sh_q     <= '0;
      tx_q     <= '0;
      ptr_q    <= '0;
      ack_q    <= 1'b0;
      rw_q     <= 1'b0;
      nack_q   <= 1'b0;
      sda_oe_n <= 1'b1;
    end else if (bus_start) begin
      st_q     <= SER_ADDR;
      bit_q    <= '0;
      ack_q    <= 1'b0;
      sda_oe_n <= 1'b1;
    end else if (bus_stop) begin
      st_q     <= SER_IDLE;
      sda_oe_n <= 1'b1;
    end else if (scl_rise && st_q != SER_IDLE) begin
      if (ack_q) begin
        nack_q <= sda_f;
      end else begin
        sh_q  <= {sh_q[6:0], sda_f};
        bit_q <= bit_q + 4'h1;
      end
    end else if (scl_fall && st_q != SER_IDLE) begin
      if (!ack_q && bit_q == BYTE_BITS) begin
        ack_q    <= 1'b1;
        bit_q    <= '0;
        sda_oe_n <= 1'b1;
        case (st_q)
          SER_ADDR: begin
            rw_q     <= sh_q[0];
            sda_oe_n <= (sh_q[7:1] != DEV_ADDR);
            if (sh_q[7:1] != DEV_ADDR) begin
              st_q <= SER_IDLE;
            end
          end
          SER_REG: begin
            ptr_q    <= sh_q;
            sda_oe_n <= 1'b0;
          end
          SER_WDATA: begin
            ptr_q    <= ptr_q + 8'h01;
            sda_oe_n <= 1'b0;
          end
          default: sda_oe_n <= 1'b1;
        endcase
      end else if (ack_q) begin
        ack_q    <= 1'b0;
        sda_oe_n <= 1'b1;
        case (st_q)
          SER_ADDR: begin
            if (rw_q) begin
              st_q     <= SER_RDATA;
              tx_q     <= rd_val;
              sda_oe_n <= rd_val[7];
            end else begin
              st_q <= SER_REG;
            end
          end
          SER_REG:   st_q <= SER_WDATA;
          SER_WDATA: st_q <= SER_WDATA;
          SER_RDATA: begin
            // Host nack ends the read burst
            if (nack_q) begin
              st_q <= SER_IDLE;
            end else begin
              ptr_q    <= ptr_q + 8'h01;
              tx_q     <= rd_next;
              sda_oe_n <= rd_next[7];
            end
          end
          default: st_q <= SER_IDLE;
        endcase
      end else if (st_q == SER_RDATA) begin
        if (bit_q == BYTE_BITS) begin
          ack_q    <= 1'b1;
          bit_q    <= '0;
          sda_oe_n <= 1'b1;
        end else begin
          sda_oe_n <= tx_q[~bit_q[2:0]];
        end
      end
    end
  end

  // ----------------------------------------
  // Registers, reloaded with reset values by power-down
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bright_q <= RST_BRIGHT;
      mode_q   <= RST_MODE;
      dc_q     <= RST_DC;
    end else if (shutdown) begin
      bright_q <= RST_BRIGHT;
      mode_q   <= RST_MODE;
      dc_q     <= RST_DC;
    end else if (wr_en) begin
      case (ptr_q)
        ADDR_BRIGHT: bright_q <= sh_q;
        ADDR_MODE:   mode_q   <= sh_q;
        ADDR_DC:     dc_q     <= sh_q;
        default:     dc_q     <= dc_q;
      endcase
    end
  end

  // ----------------------------------------
  // Dimming period and input duty capture
  // ----------------------------------------
  logic [15:0] div_q;
  logic        step_tick;
  logic [7:0]  step_q;
  logic [7:0]  hi_cnt_q;
  logic [7:0]  duty_q;

  assign step_tick = (div_q == 16'(STEP_DIV - 1));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_q  <= '0;
      step_q <= '0;
    end else if (step_tick) begin
      div_q  <= '0;
      step_q <= (step_q == LAST_STEP) ? 8'h00 : step_q + 8'h01;
    end else begin
      div_q  <= div_q + 16'h1;
    end
  end

  // 255 samples per period give an 8-bit duty directly
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hi_cnt_q <= '0;
      duty_q   <= 8'hFF;
    end else if (step_tick) begin
      if (step_q == LAST_STEP) begin
        duty_q   <= hi_cnt_q + {7'h00, pwm_f};
        hi_cnt_q <= '0;
      end else begin
        hi_cnt_q <= hi_cnt_q + {7'h00, pwm_f};
      end
    end
  end

  // ----------------------------------------
  // Level select and common gate
  // ----------------------------------------
  logic [15:0] prod;
  logic [7:0]  level;
  logic        gate_q;

  assign prod = duty_q * bright_q;

  always_comb begin
    level = prod[15:8];
    if (pins_gnd_q || mode_q == MODE_EXT) begin
      level = duty_q;
    end else if (mode_q == MODE_REG) begin
      level = bright_q;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gate_q <= 1'b0;
    end else if (direct_q) begin
      gate_q <= pwm_f;
    end else begin
      gate_q <= (step_q < level);
    end
  end

  // Current level only matters while the gate is on
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ch_current_level <= RST_DC;
    end else begin
      ch_current_level <= dc_q;
    end
  end

  genvar gc;
  generate
    for (gc = 0; gc < NCH; gc++) begin : g_ch
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          ch_on[gc] <= 1'b0;
        end else begin
          ch_on[gc] <= gate_q & (dc_q != 8'h00) & ~shutdown;
        end
      end
    end
  endgenerate

endmodule

//--- shared/ldpwm_pkg.sv
// Operation
// - Enable low over 30 ms shuts down
// - DC level 0..255, resets to 255
// - DC level changes apply while running
// - DC level zero disconnects all channels
// - On-current scales linearly with DC level
// - One common gate drives all six channels
// - Register mode: internal 255-step PWM duty
// - Ratiometric duty is input duty times brightness
// - Direct mode follows input frequency and duty
// - Reset dimming method is ratiometric
// - Register mode average is level over 255
// - Brightness register 0..255, resets to 0xFF
// - Brightness zero disconnects all channels, except in mode 0x03 or with grounded bus pins
// - Mode 0x01 with input high follows brightness; code sets level one below nonzero brightness (254 at 0xFF)
// - Ratiometric uses top 8 product bits
// - Input low over 30.5 ms shuts down, except in mode 0x05 without grounded bus pins
package ldpwm_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_BRIGHT  = 8'h00;
  localparam logic [7:0] ADDR_MODE    = 8'h01;
  localparam logic [7:0] ADDR_DC      = 8'h07;
  localparam logic [7:0] RST_BRIGHT   = 8'hFF;
  localparam logic [7:0] RST_MODE     = 8'h01;
  localparam logic [7:0] RST_DC       = 8'hFF;

  // ----------------------------------------
  // Dimming method codes
  // ----------------------------------------
  localparam logic [7:0] MODE_RATIO   = 8'h01;
  localparam logic [7:0] MODE_EXT     = 8'h03;
  localparam logic [7:0] MODE_REG     = 8'h05;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int         CLK_MHZ      = 25;
  localparam int         EN_LOW_US    = 30000;
  localparam int         PWM_LOW_US   = 30500;
  localparam int         EN_LOW_CYC   = EN_LOW_US * CLK_MHZ;
  localparam int         PWM_LOW_CYC  = PWM_LOW_US * CLK_MHZ;
  localparam logic [7:0] LAST_STEP    = 8'hFE;
  localparam logic [2:0] STRAP_AT     = 3'h6;
  localparam logic [3:0] BYTE_BITS    = 4'h8;

  // ----------------------------------------
  // Pin index in the synchroniser bank
  // ----------------------------------------
  localparam int         PIN_SCL      = 0;
  localparam int         PIN_SDA      = 1;
  localparam int         PIN_EN       = 2;
  localparam int         PIN_PWM      = 3;
  localparam int         PIN_FREQ     = 4;
  localparam int         NPINS        = 5;
  localparam logic [4:0] PIN_RST      = 5'h03;

  typedef enum logic [2:0] {
    SER_IDLE,
    SER_ADDR,
    SER_REG,
    SER_WDATA,
    SER_RDATA
  } ldpwm_ser_t;

endpackage

//--- test/ldpwm_asserts.sv
`timescale 1ns/1ps
module ldpwm_asserts #(
  parameter int EN_LOW_CNT = 50
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Watched pins
  input  wire logic       en_i,
  input  wire logic       sda_o,
  input  wire logic       sda_oe_n,
  input  wire logic [5:0] ch_on,
  input  wire logic [7:0] ch_current_level,
  input  wire logic       shutdown
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  // Raw enable-low run length; margin below covers the pin synchroniser
  int unsigned low_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      low_q <= 0;
    end else begin
      low_q <= en_i ? 0 : low_q + 1;
    end
  end

  sequence s_dc_off;
    ch_current_level == 8'h00 [*3];
  endsequence
  sequence s_shut;
    shutdown [*3];
  endsequence

  property p_dc_zero;
    s_dc_off |-> ch_on == 6'h00;
  endproperty
  property p_common;
    ch_on == 6'h00 || ch_on == 6'h3F;
  endproperty
  property p_en_long;
    low_q > EN_LOW_CNT + 8 |-> shutdown;
  endproperty
  property p_shut_gate;
    s_shut |-> ch_on == 6'h00;
  endproperty
  property p_rst_dc;
    $rose(arst_n) |-> ch_current_level == 8'hFF;
  endproperty
  property p_shut_dflt;
    s_shut |-> ch_current_level == 8'hFF;
  endproperty
  property p_ack_hold;
    $fell(sda_oe_n) |-> !sda_oe_n [*8];
  endproperty
  property p_od_low;
    sda_o == 1'b0;
  endproperty

  a_dc_zero:   assert property (p_dc_zero) else $error("channel on with zero dc level");
  a_common:    assert property (p_common) else $error("channels differ");
  a_en_long:   assert property (p_en_long) else $error("no shutdown after long enable low");
  a_shut_gate: assert property (p_shut_gate) else $error("channel on in shutdown");
  a_rst_dc:    assert property (p_rst_dc) else $error("dc level not full after reset");
  a_shut_dflt: assert property (p_shut_dflt) else $error("dc level not default in shutdown");
  a_ack_hold:  assert property (p_ack_hold) else $error("acknowledge too short");
  a_od_low:    assert property (p_od_low) else $error("data pin drives high");
endmodule

//--- test/ldpwm_bench.sv
`timescale 1ns/1ps
module ldpwm_bench;
  import ldpwm_pkg::*;
  localparam int SD  = 2;
  localparam int PER = 255 * SD;
  logic       clk, arst_n, en, strap, scl, sda, sda_o, sda_oe_n, pwm, shutdown;
  logic [5:0] ch_on;
  logic [7:0] lvl, q;
  int         errors, checks, cyc;
  logic [7:0] tm [5] = '{MODE_REG, MODE_REG, MODE_RATIO, MODE_RATIO, MODE_EXT};
  logic [7:0] tb [5] = '{8'h80, 8'h00, 8'h80, 8'h00, 8'h80};
  int         te [5] = '{128, 0, (153 * 128) >> 8, 0, 153};

  ldpwm_top #(.STEP_DIV(SD), .EN_LOW_CNT(50), .PWM_LOW_CNT(60)) ldpwm_top_inst (
    .clk(clk), .arst_n(arst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .en_i(en), .pwm_i(pwm), .dimming_freq_resistor_pin_high(strap), .ch_on(ch_on),
    .ch_current_level(lvl), .shutdown(shutdown));
  ldpwm_host ldpwm_host_inst (.clk(clk), .sda_oe_n(sda_oe_n), .scl(scl), .sda(sda), .pwm(pwm));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      errors++;
      results();
    end
  end

  task automatic results();
    if (errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // On-time over one whole period, after the input duty has settled
  task automatic duty(input logic [15:0] exp);
    logic [15:0] n;
    n = 16'h0000;
    repeat (3 * PER) @(posedge clk);
    repeat (PER) begin
      @(posedge clk);
      n += 16'(ch_on[0]);
    end
    chk(n, exp);
  endtask

  initial begin
    arst_n = 1'b0;
    en = 1'b1;
    strap = 1'b0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (12) @(posedge clk);
    ldpwm_host_inst.rd(ADDR_BRIGHT, q);
    chk(16'(q), 16'(RST_BRIGHT));
    ldpwm_host_inst.rd(ADDR_MODE, q);
    chk(16'(q), 16'(RST_MODE));
    ldpwm_host_inst.rd(ADDR_DC, q);
    chk(16'(q), 16'(RST_DC));
    ldpwm_host_inst.rd(8'h02, q);
    chk(16'(q), 16'h0000);
    duty(16'(254 * SD));
    ldpwm_host_inst.per_n = 10;
    ldpwm_host_inst.hi_n = 6;
    for (int i = 0; i < 5; i++) begin
      ldpwm_host_inst.wr(ADDR_MODE, tm[i]);
      ldpwm_host_inst.wr(ADDR_BRIGHT, tb[i]);
      duty(16'(te[i] * SD));
    end
    ldpwm_host_inst.wr(ADDR_DC, 8'h40);
    repeat (4) @(posedge clk);
    chk(16'(lvl), 16'h0040);
    ldpwm_host_inst.wr(ADDR_DC, 8'h00);
    duty(16'h0000);
    en <= 1'b0;
    repeat (40) @(posedge clk);
    chk(16'(shutdown), 16'h0000);
    en <= 1'b1;
    repeat (10) @(posedge clk);
    en <= 1'b0;
    repeat (70) @(posedge clk);
    chk(16'(shutdown), 16'h0001);
    en <= 1'b1;
    repeat (10) @(posedge clk);
    chk(16'(shutdown), 16'h0000);
    ldpwm_host_inst.rd(ADDR_DC, q);
    chk(16'(q), 16'(RST_DC));
    ldpwm_host_inst.per_n = 0;
    ldpwm_host_inst.hi_n = 0;
    repeat (80) @(posedge clk);
    chk(16'(shutdown), 16'h0001);
    ldpwm_host_inst.hi_n = 1;
    repeat (10) @(posedge clk);
    chk(16'(shutdown), 16'h0000);
    // Grounded bus pins and strap select direct dimming at reset
    arst_n <= 1'b0;
    strap <= 1'b1;
    ldpwm_host_inst.scl <= 1'b0;
    ldpwm_host_inst.sda_drv <= 1'b0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    ldpwm_host_inst.per_n = 10;
    ldpwm_host_inst.hi_n = 6;
    duty(16'(51 * 6));
    results();
  end
endmodule

bind ldpwm_top ldpwm_asserts #(.EN_LOW_CNT(EN_LOW_CNT)) ldpwm_asserts_inst (
  .clk(clk), .arst_n(arst_n), .en_i(en_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
  .ch_on(ch_on), .ch_current_level(ch_current_level), .shutdown(shutdown));

//--- test/ldpwm_host.sv
`timescale 1ns/1ps
module ldpwm_host #(
  parameter logic [6:0] DEV = 7'h2C  // Arbitrary value
) (
  // Clock
  input  wire logic clk,
  // Serial bus
  input  wire logic sda_oe_n,
  output logic      scl,
  output logic      sda,
  // Dimming source
  output logic      pwm
);
  logic sda_drv = 1'b1;
  int   hi_n = 1;
  int   per_n = 0;
  int   ph = 0;

  // Pull-up: high unless a party pulls low
  assign sda = sda_drv & sda_oe_n;
  initial scl = 1'b1;

  // Per 0 gives a steady level of hi_n
  always @(posedge clk) begin
    ph <= (ph + 1 >= per_n) ? 0 : ph + 1;
    pwm <= (per_n == 0) ? (hi_n != 0) : (ph < hi_n);
  end

  task automatic wt();
    repeat (12) @(posedge clk);
  endtask
  task automatic start();
    sda_drv <= 1'b1;
    wt();
    scl <= 1'b1;
    wt();
    sda_drv <= 1'b0;
    wt();
    scl <= 1'b0;
  endtask
  task automatic stop();
    wt();
    sda_drv <= 1'b0;
    wt();
    scl <= 1'b1;
    wt();
    sda_drv <= 1'b1;
    wt();
  endtask
  task automatic bit_io(input logic d, output logic q);
    wt();
    sda_drv <= d;
    wt();
    scl <= 1'b1;
    wt();
    q = sda;
    scl <= 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ai, a);
  endtask
  task automatic wr(input logic [7:0] r, input logic [7:0] d);
    logic [7:0] q;
    logic       a;
    start();
    xfer({DEV, 1'b0}, 1'b1, q, a);
    xfer(r, 1'b1, q, a);
    xfer(d, 1'b1, q, a);
    stop();
  endtask
  task automatic rd(input logic [7:0] r, output logic [7:0] d);
    logic [7:0] q;
    logic       a;
    start();
    xfer({DEV, 1'b0}, 1'b1, q, a);
    xfer(r, 1'b1, q, a);
    start();
    xfer({DEV, 1'b1}, 1'b1, q, a);
    xfer(8'hFF, 1'b1, d, a);
    stop();
  endtask
endmodule
